// >>> rtl/ufes_defines.svh
// Constants for the endpoint stall and buffer control block
`ifndef UFES_DEFINES_SVH
`define UFES_DEFINES_SVH
`define UFES_NUM_EP        4
`define UFES_EP_BULK_OUT   1
`define UFES_EP_BULK_IN    2
`define UFES_SETUP_BYTES   4'h8
`define UFES_PKT_MAX       7'h40
`define UFES_FIFO_DEPTH    32
`define UFES_FIFO_AW       5
`define UFES_REQ_CLR_FEAT  8'h01
`define UFES_REQ_SET_FEAT  8'h03
`define UFES_REQ_GET_STAT  8'h00
`define UFES_REQ_SET_ADDR  8'h05
`define UFES_REQ_GET_DESC  8'h06
`define UFES_REQ_SET_DESC  8'h07
`define UFES_REQ_GET_CONF  8'h08
`define UFES_REQ_SET_CONF  8'h09
`define UFES_REQ_GET_INTF  8'h0a
`define UFES_REQ_SET_INTF  8'h0b
`define UFES_REQ_SYNC      8'h0c
`endif

// >>> rtl/ufes_pkg.sv
// Types for the endpoint stall and buffer control block
package ufes_pkg;
    typedef enum logic [1:0] {
        HS_ACK   = 2'b00,
        HS_NAK   = 2'b01,
        HS_STALL = 2'b10
    } ufes_hs_e;
    typedef enum logic [1:0] {
        TK_OUT   = 2'b00,
        TK_IN    = 2'b01,
        TK_SETUP = 2'b10
    } ufes_tok_e;
endpackage : ufes_pkg

// >>> rtl/ufes_fifo.sv
// Parameterised valid/ready FIFO for the setup packet path
`timescale 1ns/1ps
module ufes_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    logic [AW:0]      nxt_wrPtr;
    logic [AW:0]      nxt_rdPtr;
    logic             doWr;
    logic             doRd;
    logic [AW-1:0]    wrAddr;

    assign inReady  = flush || (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[rdPtr_ff[AW-1:0]];
    // A write in the flush cycle lands at entry zero, so no byte is lost
    assign wrAddr   = flush ? '0 : wrPtr_ff[AW-1:0];

    always_comb begin
        nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
        nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
        if (flush) begin
            nxt_wrPtr = {{AW{1'b0}}, doWr};
            nxt_rdPtr = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
        end
        if (doWr) begin
            mem[wrAddr] <= inData;
        end
    end
endmodule : ufes_fifo

// >>> rtl/ufes_ep_ctrl.sv
// Endpoint control: request split, stall state, setup FIFO, dual buffers
`timescale 1ns/1ps
`include "ufes_defines.svh"
module ufes_ep_ctrl (
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Transaction from the serial engine
    input  wire logic                     tokValid,
    input  wire ufes_pkg::ufes_tok_e      tokType,
    input  wire logic [1:0]               tokEp,
    input  wire logic                     protoViolation,
    input  wire logic                     outPktDone,
    input  wire logic [6:0]               outPktLen,
    input  wire logic                     inPktAcked,
    output ufes_pkg::ufes_hs_e            hsReply,
    output logic                          hsValid,
    // Setup packet bytes from the bus side
    input  wire logic                     setupByteValid,
    input  wire logic [7:0]               setupByte,
    input  wire logic                     setupDone,
    output logic                          setupByteReady,
    output logic                          autoRequestDone,
    // Firmware side
    input  wire logic [`UFES_NUM_EP-1:0]  stallRequestRegister,
    input  wire logic                     setupDataRead,
    output logic [7:0]                    setupDataPort,
    output logic                          setupDataValid,
    output logic                          setupReceivedFlag,
    input  wire logic                     setupFlagClear,
    output logic                          setupReadAborted,
    output logic [`UFES_NUM_EP-1:0]       hiddenStall,
    input  wire logic                     bulkOutReadDoneTrigger,
    input  wire logic                     bulkOutClear,
    input  wire logic                     bulkOutDmaEnable,
    output logic [6:0]                    bulkOutRxSize,
    output logic                          bulkOutFull,
    input  wire logic                     packetCommitTrigger,
    output logic                          bulkInEmpty,
    output logic [`UFES_NUM_EP-1:0]       inTokenNakFlag,
    input  wire logic [`UFES_NUM_EP-1:0]  inTokenNakClear,
    input  wire logic [`UFES_NUM_EP-1:0]  inFifoHasData
);
    logic [`UFES_NUM_EP-1:0] stall_ff, nxt_stall;
    logic [7:0]              req_ff [8];
    logic [7:0]              nxt_req [8];
    logic [3:0]              setCnt_ff, nxt_setCnt;
    logic [3:0]              rdCnt_ff, nxt_rdCnt;
    logic                    flag_ff, nxt_flag;
    logic                    abort_ff, nxt_abort;
    logic                    auto_ff, nxt_auto;
    logic [1:0]              hs_ff, nxt_hs;
    logic                    hsv_ff, nxt_hsv;
    logic [1:0]              oFull_ff, nxt_oFull;
    logic                    oRd_ff, nxt_oRd;
    logic                    oWr_ff, nxt_oWr;
    logic [6:0]              oLen_ff [2];
    logic [6:0]              nxt_oLen [2];
    logic [1:0]              iFull_ff, nxt_iFull;
    logic                    iWr_ff, nxt_iWr;
    logic                    iTx_ff, nxt_iTx;
    logic [`UFES_NUM_EP-1:0] tr_ff, nxt_tr;
    logic                    pendNak_ff, nxt_pendNak;
    logic [1:0]              pendEp_ff, nxt_pendEp;
    logic                    isStd;
    logic                    fifoValid;
    logic [7:0]              fifoData;
    logic                    fifoPop;
    logic                    setupStart;

    assign setupStart = setupByteValid && setCnt_ff == 4'h0;
    assign fifoPop    = setupDataRead && fifoValid && !setupByteValid;

    ufes_fifo #(.WIDTH(8), .DEPTH(`UFES_FIFO_DEPTH), .AW(`UFES_FIFO_AW)) u_setup_fifo (
        .clk      (clk),
        .srst     (srst),
        // All eight bytes enter; a standard request is dropped once decoded
        .flush    (setupStart || (setupDone && isStd)),
        .inValid  (setupByteValid && setCnt_ff < `UFES_SETUP_BYTES),
        .inReady  (setupByteReady),
        .inData   (setupByte),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    always_comb begin
        case (req_ff[1])
            `UFES_REQ_GET_DESC, `UFES_REQ_SET_DESC, `UFES_REQ_SYNC: isStd = 1'b0;
            `UFES_REQ_CLR_FEAT, `UFES_REQ_SET_FEAT, `UFES_REQ_GET_STAT,
            `UFES_REQ_SET_ADDR, `UFES_REQ_GET_CONF, `UFES_REQ_SET_CONF,
            `UFES_REQ_GET_INTF, `UFES_REQ_SET_INTF: isStd = req_ff[0][6:5] == 2'b00;
            default: isStd = 1'b0;
        endcase
    end

    always_comb begin
        nxt_req    = req_ff;
        nxt_setCnt = setCnt_ff;
        nxt_rdCnt  = rdCnt_ff;
        nxt_flag   = flag_ff;
        nxt_abort  = 1'b0;
        nxt_auto   = 1'b0;
        if (setupFlagClear) begin
            nxt_flag = 1'b0;
        end
        if (setupByteValid && setCnt_ff < `UFES_SETUP_BYTES) begin
            nxt_req[setCnt_ff[2:0]] = setupByte;
            nxt_setCnt = setCnt_ff + 4'h1;
        end
        if (setupStart && rdCnt_ff != 4'h0) begin
            nxt_abort = 1'b1;
            nxt_rdCnt = 4'h0;
        end else if (fifoPop) begin
            nxt_rdCnt = (rdCnt_ff == `UFES_SETUP_BYTES - 4'h1) ? 4'h0 : rdCnt_ff + 4'h1;
        end
        if (setupDone) begin
            nxt_setCnt = 4'h0;
            if (!isStd) begin
                nxt_flag = 1'b1;
            end else begin
                nxt_auto = 1'b1;
            end
        end
    end

    always_comb begin
        nxt_stall   = stall_ff;
        nxt_hs      = hs_ff;
        nxt_hsv     = 1'b0;
        nxt_tr      = tr_ff & ~inTokenNakClear;
        nxt_pendNak = 1'b0;
        nxt_pendEp  = tokEp;
        nxt_oFull   = oFull_ff;
        nxt_oRd     = oRd_ff;
        nxt_oWr     = oWr_ff;
        nxt_oLen    = oLen_ff;
        nxt_iFull   = iFull_ff;
        nxt_iWr     = iWr_ff;
        nxt_iTx     = iTx_ff;
        if (pendNak_ff) begin
            nxt_tr[pendEp_ff] = 1'b1;
        end
        if (tokValid && tokType != ufes_pkg::TK_SETUP) begin
            nxt_hsv = 1'b1;
            if (stall_ff[tokEp] || stallRequestRegister[tokEp]) begin
                nxt_stall[tokEp] = 1'b1;
                nxt_hs = ufes_pkg::HS_STALL;
            end else if (tokType == ufes_pkg::TK_OUT && tokEp == 2'(`UFES_EP_BULK_OUT)
                         && oFull_ff == 2'b11) begin
                nxt_hs = ufes_pkg::HS_NAK;
            end else if (tokType == ufes_pkg::TK_IN && !inFifoHasData[tokEp]) begin
                nxt_hs = ufes_pkg::HS_NAK;
                nxt_pendNak = 1'b1;
            end else begin
                nxt_hs = ufes_pkg::HS_ACK;
            end
        end else if (tokValid) begin
            nxt_hsv = 1'b1;
            nxt_hs  = ufes_pkg::HS_ACK;
        end
        if (protoViolation && tokValid) begin
            nxt_stall[tokEp] = 1'b1;
            nxt_hs = ufes_pkg::HS_STALL;
        end
        if (auto_ff && req_ff[0][1:0] == 2'b10) begin
            if (req_ff[1] == `UFES_REQ_SET_FEAT) begin
                nxt_stall[req_ff[4][1:0]] = 1'b1;
            end else if (req_ff[1] == `UFES_REQ_CLR_FEAT) begin
                nxt_stall[req_ff[4][1:0]] = 1'b0;
            end
        end
        if (outPktDone && oFull_ff[oWr_ff] == 1'b0) begin
            nxt_oFull[oWr_ff] = 1'b1;
            nxt_oLen[oWr_ff]  = outPktLen;
            nxt_oWr           = ~oWr_ff;
        end
        if (bulkOutReadDoneTrigger && oFull_ff[oRd_ff]) begin
            nxt_oFull[oRd_ff] = 1'b0;
            nxt_oRd           = ~oRd_ff;
        end
        if (bulkOutClear && !bulkOutDmaEnable) begin
            nxt_oFull = 2'b00;
            nxt_oRd   = 1'b0;
            nxt_oWr   = 1'b0;
        end
        if (packetCommitTrigger && !iFull_ff[iWr_ff]) begin
            nxt_iFull[iWr_ff] = 1'b1;
            nxt_iWr           = ~iWr_ff;
        end
        if (inPktAcked && iFull_ff[iTx_ff]) begin
            nxt_iFull[iTx_ff] = 1'b0;
            nxt_iTx           = ~iTx_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            req_ff     <= '{default: 8'h00};
            setCnt_ff  <= 4'h0;
            rdCnt_ff   <= 4'h0;
            flag_ff    <= 1'b0;
            abort_ff   <= 1'b0;
            auto_ff    <= 1'b0;
            stall_ff   <= '0;
            hs_ff      <= 2'b00;
            hsv_ff     <= 1'b0;
            tr_ff      <= '0;
            pendNak_ff <= 1'b0;
            pendEp_ff  <= 2'h0;
            oFull_ff   <= 2'b00;
            oRd_ff     <= 1'b0;
            oWr_ff     <= 1'b0;
            oLen_ff    <= '{default: 7'h00};
            iFull_ff   <= 2'b00;
            iWr_ff     <= 1'b0;
            iTx_ff     <= 1'b0;
        end else begin
            req_ff     <= nxt_req;
            setCnt_ff  <= nxt_setCnt;
            rdCnt_ff   <= nxt_rdCnt;
            flag_ff    <= nxt_flag;
            abort_ff   <= nxt_abort;
            auto_ff    <= nxt_auto;
            stall_ff   <= nxt_stall;
            hs_ff      <= nxt_hs;
            hsv_ff     <= nxt_hsv;
            tr_ff      <= nxt_tr;
            pendNak_ff <= nxt_pendNak;
            pendEp_ff  <= nxt_pendEp;
            oFull_ff   <= nxt_oFull;
            oRd_ff     <= nxt_oRd;
            oWr_ff     <= nxt_oWr;
            oLen_ff    <= nxt_oLen;
            iFull_ff   <= nxt_iFull;
            iWr_ff     <= nxt_iWr;
            iTx_ff     <= nxt_iTx;
        end
    end

    assign hsReply           = ufes_pkg::ufes_hs_e'(hs_ff);
    assign hsValid           = hsv_ff;
    assign setupDataPort     = fifoData;
    assign setupDataValid    = fifoValid;
    assign setupReceivedFlag = flag_ff;
    assign setupReadAborted  = abort_ff;
    assign autoRequestDone   = auto_ff;
    assign hiddenStall       = stall_ff;
    assign inTokenNakFlag    = tr_ff;
    assign bulkOutFull       = oFull_ff[oRd_ff];
    // Size of the buffer firmware reads now; zero when it is empty
    assign bulkOutRxSize     = oFull_ff[oRd_ff] ? oLen_ff[oRd_ff] : 7'h00;
    assign bulkInEmpty       = iFull_ff != 2'b11;

    stall_req_a: assert property (@(posedge clk) disable iff (srst)
        tokValid && tokType != ufes_pkg::TK_SETUP && stallRequestRegister[tokEp]
        |=> hsReply == ufes_pkg::HS_STALL && hsValid)
        else $error("stall request not answered with STALL");
    stall_hold_a: assert property (@(posedge clk) disable iff (srst)
        !auto_ff |=> (stall_ff & $past(stall_ff)) == $past(stall_ff))
        else $error("hidden stall dropped without clear feature");
    nak_flag_a: assert property (@(posedge clk) disable iff (srst)
        tokValid && tokType == ufes_pkg::TK_IN && !inFifoHasData[tokEp]
        && !stall_ff[tokEp] && !stallRequestRegister[tokEp] && !protoViolation
        |=> hsReply == ufes_pkg::HS_NAK ##1 inTokenNakFlag[$past(tokEp, 2)])
        else $error("token NAK flag not set after NAK");
    bulk_nak_a: assert property (@(posedge clk) disable iff (srst)
        tokValid && tokType == ufes_pkg::TK_OUT && tokEp == 2'h1 && oFull_ff == 2'b11
        && !stall_ff[1] && !stallRequestRegister[1] && !protoViolation
        |=> hsReply == ufes_pkg::HS_NAK)
        else $error("bulk out not NAKed when both buffers full");
    dma_clear_a: assert property (@(posedge clk) disable iff (srst)
        bulkOutClear && bulkOutDmaEnable && !bulkOutReadDoneTrigger && !outPktDone
        |=> oFull_ff == $past(oFull_ff))
        else $error("bulk out cleared while DMA enabled");
    in_empty_a: assert property (@(posedge clk) disable iff (srst)
        packetCommitTrigger && iFull_ff != 2'b00 && !iFull_ff[iWr_ff] && !inPktAcked
        |=> !bulkInEmpty)
        else $error("bulk in empty flag set with both buffers full");
    setup_flag_a: assert property (@(posedge clk) disable iff (srst)
        setupDone && !isStd |=> setupReceivedFlag && !autoRequestDone)
        else $error("setup flag not raised for firmware request");
    auto_req_a: assert property (@(posedge clk) disable iff (srst)
        setupDone && isStd && !setupReceivedFlag |=> autoRequestDone && !setupReceivedFlag)
        else $error("standard request raised setup flag");
    read_done_a: assert property (@(posedge clk) disable iff (srst)
        bulkOutReadDoneTrigger && oFull_ff[oRd_ff] && !(bulkOutClear && !bulkOutDmaEnable)
        |=> oRd_ff != $past(oRd_ff))
        else $error("read done did not switch buffer");
endmodule : ufes_ep_ctrl

// >>> tb/ufes_host_model.sv
// Host and serial-engine model: tokens, setup packets, bulk events
`timescale 1ns/1ps
`include "ufes_defines.svh"
module ufes_host_model (
    input  wire logic           clk,
    input  wire logic           setupByteReady,
    output logic                tokValid,
    output ufes_pkg::ufes_tok_e tokType,
    output logic [1:0]          tokEp,
    output logic                protoViolation,
    output logic                outPktDone,
    output logic [6:0]          outPktLen,
    output logic                inPktAcked,
    output logic                setupByteValid,
    output logic [7:0]          setupByte,
    output logic                setupDone
);
    initial begin
        {tokValid, protoViolation, outPktDone, inPktAcked} = 4'h0;
        {setupByteValid, setupDone, tokEp, outPktLen} = 11'h0;
        tokType   = ufes_pkg::TK_OUT;
        setupByte = 8'h00;
    end
    // Entered just after an edge; the token is taken at the next edge
    task automatic token(input ufes_pkg::ufes_tok_e t, input logic [1:0] ep, input logic bad);
        tokValid       = 1'b1;
        tokType        = t;
        tokEp          = ep;
        protoViolation = bad;
        @(posedge clk);
        #1;
        tokValid       = 1'b0;
        protoViolation = 1'b0;
        // Released tokValid and protoViolation go low; tokEp never keeps its last value
        tokEp          = ~ep;
    endtask : token
    task automatic setup(input logic [7:0] kind, input logic [7:0] req, input logic [1:0] ep);
        logic [7:0] pkt [8];
        pkt = '{kind, req, 8'ha5, 8'h5a, {6'h00, ep}, 8'h00, {4'h0, `UFES_SETUP_BYTES}, 8'h00};
        for (int i = 0; i < 8; i++) begin
            setupByteValid = 1'b1;
            setupByte      = pkt[i];
            do @(posedge clk); while (setupByteReady !== 1'b1);
            #1;
        end
        setupByteValid = 1'b0;
        setupByte      = ~pkt[7];
        setupDone      = 1'b1;
        @(posedge clk);
        #1;
        setupDone      = 1'b0;
    endtask : setup
    task automatic out_pkt(input logic [6:0] len);
        outPktDone = 1'b1;
        outPktLen  = len;
        @(posedge clk);
        #1;
        outPktDone = 1'b0;
        outPktLen  = ~len;
    endtask : out_pkt
    task automatic ack_in();
        inPktAcked = 1'b1;
        @(posedge clk);
        #1;
        inPktAcked = 1'b0;
    endtask : ack_in
endmodule : ufes_host_model

// >>> tb/tb_top.sv
// Self-checking bench for the endpoint control block
`timescale 1ns/1ps
`include "ufes_defines.svh"
module tb_top;
    logic clk, srst, tokValid, protoViolation, outPktDone, inPktAcked, hsValid;
    logic setupByteValid, setupDone, setupByteReady, autoRequestDone, setupDataRead;
    logic setupDataValid, setupReceivedFlag, setupFlagClear, setupReadAborted;
    logic bulkOutReadDoneTrigger, bulkOutClear, bulkOutDmaEnable, bulkOutFull;
    logic packetCommitTrigger, bulkInEmpty;
    logic [1:0] tokEp;
    logic [6:0] outPktLen, bulkOutRxSize;
    logic [7:0] setupByte, setupDataPort;
    logic [3:0] stallRequestRegister, hiddenStall, inTokenNakFlag, inTokenNakClear, inFifoHasData;
    ufes_pkg::ufes_tok_e tokType;
    ufes_pkg::ufes_hs_e  hsReply;
    int bad_count = 0;
    int checked   = 0;
    ufes_host_model host (.clk(clk), .setupByteReady(setupByteReady), .tokValid(tokValid),
        .tokType(tokType), .tokEp(tokEp), .protoViolation(protoViolation),
        .outPktDone(outPktDone), .outPktLen(outPktLen), .inPktAcked(inPktAcked),
        .setupByteValid(setupByteValid), .setupByte(setupByte), .setupDone(setupDone));
    ufes_ep_ctrl dut (.clk(clk), .srst(srst), .tokValid(tokValid), .tokType(tokType),
        .tokEp(tokEp), .protoViolation(protoViolation), .outPktDone(outPktDone),
        .outPktLen(outPktLen), .inPktAcked(inPktAcked), .hsReply(hsReply), .hsValid(hsValid),
        .setupByteValid(setupByteValid), .setupByte(setupByte), .setupDone(setupDone),
        .setupByteReady(setupByteReady), .autoRequestDone(autoRequestDone),
        .stallRequestRegister(stallRequestRegister), .setupDataRead(setupDataRead),
        .setupDataPort(setupDataPort), .setupDataValid(setupDataValid),
        .setupReceivedFlag(setupReceivedFlag), .setupFlagClear(setupFlagClear),
        .setupReadAborted(setupReadAborted), .hiddenStall(hiddenStall),
        .bulkOutReadDoneTrigger(bulkOutReadDoneTrigger), .bulkOutClear(bulkOutClear),
        .bulkOutDmaEnable(bulkOutDmaEnable), .bulkOutRxSize(bulkOutRxSize),
        .bulkOutFull(bulkOutFull), .packetCommitTrigger(packetCommitTrigger),
        .bulkInEmpty(bulkInEmpty), .inTokenNakFlag(inTokenNakFlag),
        .inTokenNakClear(inTokenNakClear), .inFifoHasData(inFifoHasData));
    // 200 MHz is well above the floor
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("checked %0d, bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Idle edge first, so a back-to-back call never re-raises the strobe at once
    task automatic tok(input ufes_pkg::ufes_tok_e t, input logic [1:0] ep, input logic bad,
                       input ufes_pkg::ufes_hs_e hs);
        step(1);
        host.token(t, ep, bad);
        check("hsValid", 8'h01, {7'h00, hsValid});
        check("hsReply", {6'h00, hs}, {6'h00, hsReply});
    endtask : tok
    task automatic clear_feat(input logic [1:0] ep);
        host.setup(8'h02, `UFES_REQ_CLR_FEAT, ep);
        step(1);
    endtask : clear_feat
    // Firmware reads one whole group, holding the pop strobe throughout
    task automatic read_setup(input logic [7:0] kind, input logic [7:0] req);
        logic [7:0] pkt [8];
        pkt = '{kind, req, 8'ha5, 8'h5a, 8'h00, 8'h00, 8'h08, 8'h00};
        setupDataRead = 1'b1;
        for (int i = 0; i < 8; i++) begin
            check("setupDataValid", 8'h01, {7'h00, setupDataValid});
            check("setupDataPort", pkt[i], setupDataPort);
            step(1);
        end
        setupDataRead = 1'b0;
    endtask : read_setup
    task automatic t_forced_stall();
        stallRequestRegister = 4'h8;
        step(2);
        check("hiddenStall", 8'h00, {4'h0, hiddenStall});
        tok(ufes_pkg::TK_OUT, 2'd3, 1'b0, ufes_pkg::HS_STALL);
        check("hiddenStall", 8'h08, {4'h0, hiddenStall});
        stallRequestRegister = 4'h0;
        tok(ufes_pkg::TK_OUT, 2'd3, 1'b0, ufes_pkg::HS_STALL);
        tok(ufes_pkg::TK_SETUP, 2'd3, 1'b0, ufes_pkg::HS_ACK);
        stallRequestRegister = 4'h8;
        clear_feat(2'd3);
        check("hiddenStall", 8'h00, {4'h0, hiddenStall});
        tok(ufes_pkg::TK_IN, 2'd3, 1'b0, ufes_pkg::HS_STALL);
        stallRequestRegister = 4'h0;
        clear_feat(2'd3);
        tok(ufes_pkg::TK_OUT, 2'd3, 1'b0, ufes_pkg::HS_ACK);
    endtask : t_forced_stall
    task automatic t_auto_stall();
        host.setup(8'h02, `UFES_REQ_SET_FEAT, 2'd1);
        step(1);
        check("hiddenStall", 8'h02, {4'h0, hiddenStall});
        tok(ufes_pkg::TK_IN, 2'd1, 1'b0, ufes_pkg::HS_STALL);
        tok(ufes_pkg::TK_OUT, 2'd2, 1'b1, ufes_pkg::HS_STALL);
        step(1);
        check("hiddenStall", 8'h06, {4'h0, hiddenStall});
        clear_feat(2'd1);
        clear_feat(2'd2);
        check("hiddenStall", 8'h00, {4'h0, hiddenStall});
    endtask : t_auto_stall
    task automatic t_std_requests();
        logic [7:0] codes [8];
        codes = '{`UFES_REQ_CLR_FEAT, `UFES_REQ_GET_CONF, `UFES_REQ_GET_INTF, `UFES_REQ_GET_STAT,
                  `UFES_REQ_SET_ADDR, `UFES_REQ_SET_CONF, `UFES_REQ_SET_FEAT, `UFES_REQ_SET_INTF};
        foreach (codes[i]) begin
            host.setup(8'h00, codes[i], 2'd0);
            check("autoRequestDone", 8'h01, {7'h00, autoRequestDone});
            check("setupReceivedFlag", 8'h00, {7'h00, setupReceivedFlag});
        end
    endtask : t_std_requests
    task automatic t_fw_requests();
        logic [7:0] kinds [5];
        logic [7:0] reqs [5];
        kinds = '{8'h00, 8'h02, 8'h00, 8'h21, 8'h40};
        reqs  = '{`UFES_REQ_GET_DESC, `UFES_REQ_SYNC, `UFES_REQ_SET_DESC, 8'h01, 8'h10};
        foreach (kinds[i]) begin
            host.setup(kinds[i], reqs[i], 2'd0);
            check("autoRequestDone", 8'h00, {7'h00, autoRequestDone});
            check("setupReceivedFlag", 8'h01, {7'h00, setupReceivedFlag});
            read_setup(kinds[i], reqs[i]);
            setupFlagClear = 1'b1;
            step(1);
            setupFlagClear = 1'b0;
            check("setupReceivedFlag", 8'h00, {7'h00, setupReceivedFlag});
        end
    endtask : t_fw_requests
    task automatic t_abort();
        host.setup(8'h00, `UFES_REQ_GET_DESC, 2'd0);
        setupDataRead = 1'b1;
        step(3);
        setupDataRead = 1'b0;
        fork
            host.setup(8'h40, 8'h33, 2'd0);
            begin
                step(1);
                check("setupReadAborted", 8'h01, {7'h00, setupReadAborted});
            end
        join
        read_setup(8'h40, 8'h33);
        setupFlagClear = 1'b1;
        step(1);
        setupFlagClear = 1'b0;
    endtask : t_abort
    task automatic t_in_nak();
        tok(ufes_pkg::TK_IN, 2'd2, 1'b0, ufes_pkg::HS_NAK);
        check("inTokenNakFlag", 8'h00, {4'h0, inTokenNakFlag});
        step(1);
        check("inTokenNakFlag", 8'h04, {4'h0, inTokenNakFlag});
        inTokenNakClear = 4'h4;
        step(1);
        inTokenNakClear = 4'h0;
        check("inTokenNakFlag", 8'h00, {4'h0, inTokenNakFlag});
        tok(ufes_pkg::TK_IN, 2'd2, 1'b0, ufes_pkg::HS_NAK);
        step(1);
        check("inTokenNakFlag", 8'h04, {4'h0, inTokenNakFlag});
        inFifoHasData = 4'h4;
        tok(ufes_pkg::TK_IN, 2'd2, 1'b0, ufes_pkg::HS_ACK);
        inFifoHasData = 4'h0;
    endtask : t_in_nak
    task automatic t_bulk_out();
        host.out_pkt(7'h0a);
        check("bulkOutRxSize", 8'h0a, {1'b0, bulkOutRxSize});
        check("bulkOutFull", 8'h01, {7'h00, bulkOutFull});
        step(1);
        host.out_pkt(`UFES_PKT_MAX);
        tok(ufes_pkg::TK_OUT, 2'd1, 1'b0, ufes_pkg::HS_NAK);
        bulkOutDmaEnable = 1'b1;
        bulkOutClear     = 1'b1;
        step(1);
        bulkOutClear     = 1'b0;
        bulkOutDmaEnable = 1'b0;
        check("bulkOutRxSize", 8'h0a, {1'b0, bulkOutRxSize});
        bulkOutReadDoneTrigger = 1'b1;
        step(1);
        bulkOutReadDoneTrigger = 1'b0;
        check("bulkOutRxSize", 8'h40, {1'b0, bulkOutRxSize});
        tok(ufes_pkg::TK_OUT, 2'd1, 1'b0, ufes_pkg::HS_ACK);
        bulkOutClear = 1'b1;
        step(1);
        bulkOutClear = 1'b0;
        check("bulkOutFull", 8'h00, {7'h00, bulkOutFull});
        check("bulkOutRxSize", 8'h00, {1'b0, bulkOutRxSize});
    endtask : t_bulk_out
    task automatic t_bulk_in();
        check("bulkInEmpty", 8'h01, {7'h00, bulkInEmpty});
        for (int i = 0; i < 2; i++) begin
            packetCommitTrigger = 1'b1;
            step(1);
            packetCommitTrigger = 1'b0;
            check("bulkInEmpty", {7'h00, i == 0}, {7'h00, bulkInEmpty});
            step(1);
        end
        host.ack_in();
        check("bulkInEmpty", 8'h01, {7'h00, bulkInEmpty});
    endtask : t_bulk_in
    initial begin
        srst = 1'b1;
        {stallRequestRegister, inTokenNakClear} = 8'h00;
        inFifoHasData = 4'h0;
        {setupDataRead, setupFlagClear, bulkOutReadDoneTrigger, bulkOutClear} = 4'h0;
        {bulkOutDmaEnable, packetCommitTrigger} = 2'h0;
        step(4);
        srst = 1'b0;
        check("hsValid", 8'h00, {7'h00, hsValid});
        check("hiddenStall", 8'h00, {4'h0, hiddenStall});
        check("bulkInEmpty", 8'h01, {7'h00, bulkInEmpty});
        t_forced_stall();
        t_auto_stall();
        t_std_requests();
        t_fw_requests();
        t_abort();
        t_in_nak();
        t_bulk_out();
        t_bulk_in();
        stop_test();
    end
    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule : tb_top
